// >>> inc/lcd_consts.svh
// Offsets, field positions, reset values and sizes for the display timing core.
// Assumes a register port with word offsets and a 20 MHz system clock.
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

`define REG_ADDR_W 4
`define REG_CTRL_OFF 4'h0
`define REG_STAT_OFF 4'h4
`define CTRL_RESET 32'h0000_0000

`define CTRL_SIZE_LSB 0
`define CTRL_LINE_LSB 13
`define CTRL_PRE_LSB 19
`define CTRL_AC_LSB 25
`define CTRL_GEN_BIT 30
`define CTRL_GMD_BIT 31

`define STAT_UNDERRUN_BIT 0
`define STAT_AC_BIT 1
`define STAT_RUN_BIT 2
`define STAT_LEVEL_LSB 8

`define FIFO_WIDTH 32
`define FIFO_DEPTH 32
`define FIFO_LEVEL_W 6
`define WORDS_PER_QUAD 4
`define FETCH_ADDR_W 15
`define PIX_CNT_W 10
`define PH_CNT_W 8

`endif

// >>> inc/lcd_pkg.sv
// Types shared by the display timing core, the panel model and the testbench.
// Assumes lcd_consts.svh is compiled with it.
package lcd_pkg;

    // Layout of the display control register, bit 31 first.
    typedef struct packed {
        logic gray_depth_select;
        logic gray_output_enable;
        logic [4:0] ac_prescale;
        logic [5:0] pixel_prescale;
        logic [5:0] line_length;
        logic [12:0] buffer_size;
    } display_control_s;

    // Signals driven onto the panel.
    typedef struct packed {
        logic line_pulse;
        logic pixel_shift_clock;
        logic ac_bias;
        logic [3:0] pixel_data;
    } panel_s;

    // Phases of the pixel shift clock.
    typedef enum logic [1:0] {
        SH_IDLE,
        SH_LOW,
        SH_HIGH,
        SH_LINE
    } shift_state_e;

endpackage

// >>> design/lcd_fifo.sv
// Synchronous FIFO between the video fetch and the pixel shifter.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic flush,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Fill level.
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] next_level;
    logic push, pop;

    // Handshakes and pointer updates.
    always_comb begin
        in_ready = (level != DEPTH[AW:0]);
        out_valid = (level != '0);
        out_data = mem[rd_ptr];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr + AW'(push);
        next_rd_ptr = rd_ptr + AW'(pop);
        next_level = level + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_level = '0;
        end
    end

    // Pointer and level registers.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
        end
    end

    // Storage; a flushed write is dropped.
    always_ff @(posedge sys_clk) begin
        if (push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// >>> design/lcd_timing_control.sv
// Display timing core: control register, video fetch, pixel shift clock, line pulse and AC bias.
// Assumes a word-addressed register port, a memory source with valid/ready, and sys_clk as pixel source.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_timing_control (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Register port.
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Video memory fetch.
    output logic [`FETCH_ADDR_W-1:0] mem_addr,
    input wire logic mem_valid,
    input wire logic [`FIFO_WIDTH-1:0] mem_data,
    output logic mem_ready,
    // Panel.
    output lcd_pkg::panel_s panel
);
    lcd_pkg::display_control_s ctrl, next_ctrl;
    logic [31:0] next_rdata;
    logic underrun, next_underrun;
    logic ctrl_wr, run, restart, set_underrun;
    logic [`FIFO_LEVEL_W-1:0] fifo_level;
    logic fifo_in_valid, fifo_out_valid, fifo_out_ready;
    logic [`FIFO_WIDTH-1:0] fifo_out_data;

    assign ctrl_wr = reg_wr && (reg_addr == `REG_CTRL_OFF);
    assign run = (ctrl.pixel_prescale != 6'h00);
    assign restart = ctrl_wr || !run;

    // Register writes, reads and the sticky underrun flag.
    always_comb begin
        next_ctrl = ctrl;
        next_underrun = underrun;
        next_rdata = 32'h0000_0000;
        if (ctrl_wr) begin
            next_ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == `REG_STAT_OFF && reg_wdata[`STAT_UNDERRUN_BIT]) begin
            next_underrun = 1'b0;
        end
        if (set_underrun) begin
            next_underrun = 1'b1;
        end
        if (reg_rd && reg_addr == `REG_CTRL_OFF) begin
            next_rdata = ctrl;
        end else if (reg_rd && reg_addr == `REG_STAT_OFF) begin
            next_rdata[`STAT_UNDERRUN_BIT] = underrun;
            next_rdata[`STAT_AC_BIT] = panel.ac_bias;
            next_rdata[`STAT_RUN_BIT] = run;
            next_rdata[`STAT_LEVEL_LSB +: `FIFO_LEVEL_W] = fifo_level;
        end
    end

    // Register state.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= `CTRL_RESET;
            underrun <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            underrun <= next_underrun;
            reg_rdata <= next_rdata;
        end
    end

    // Words come in only while the pixel clock runs.
    lcd_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(restart),
        .in_valid(fifo_in_valid),
        .in_data(mem_data),
        .in_ready(mem_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready),
        .level(fifo_level)
    );
    assign fifo_in_valid = mem_valid && run;

    logic [`FETCH_ADDR_W-1:0] next_mem_addr;
    logic fetch_last;
    // Fetch address wraps at the end of the buffer to start a new frame.
    always_comb begin
        fetch_last = (mem_addr[`FETCH_ADDR_W-1:2] == ctrl.buffer_size)
            && (mem_addr[1:0] == 2'(`WORDS_PER_QUAD - 1));
        next_mem_addr = mem_addr;
        if (restart) begin
            next_mem_addr = '0;
        end else if (mem_valid && mem_ready) begin
            if (fetch_last) begin
                next_mem_addr = '0;
            end else begin
                next_mem_addr = mem_addr + `FETCH_ADDR_W'(1);
            end
        end
    end

    // Fetch address register.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mem_addr <= '0;
        end else begin
            mem_addr <= next_mem_addr;
        end
    end

    lcd_pkg::shift_state_e st, next_st;
    lcd_pkg::panel_s next_panel;
    logic [`PH_CNT_W-1:0] ph_cnt, next_ph_cnt, hi_len, lo_len;
    logic [`PIX_CNT_W-1:0] pix_cnt, next_pix_cnt;
    logic [4:0] ac_cnt, next_ac_cnt;
    logic [31:0] sh_word, next_sh_word;
    logic [5:0] sh_left, next_sh_left, per_word;
    logic [2:0] bpp;
    logic have_pix, next_have_pix, pix_ok, line_end;

    // Pixel width and phase lengths of one pixel period.
    always_comb begin
        if (!ctrl.gray_output_enable) begin
            bpp = 3'h1;
            per_word = 6'h20;
        end else if (ctrl.gray_depth_select) begin
            bpp = 3'h4;
            per_word = 6'h08;
        end else begin
            bpp = 3'h2;
            per_word = 6'h10;
        end
        // The sum is widened first, so that a prescale of 63 does not wrap to a zero high phase.
        hi_len = ({2'h0, ctrl.pixel_prescale} + 8'h01) >> 1;
        lo_len = {2'h0, ctrl.pixel_prescale} + 8'h01 - hi_len;
        line_end = (pix_cnt == {ctrl.line_length, 4'hf});
    end

    // Shift clock phases, pixel unpacking, line pulse and AC bias.
    always_comb begin
        next_st = st;
        next_ph_cnt = ph_cnt;
        next_pix_cnt = pix_cnt;
        next_ac_cnt = ac_cnt;
        next_sh_word = sh_word;
        next_sh_left = sh_left;
        next_have_pix = have_pix;
        next_panel = panel;
        fifo_out_ready = 1'b0;
        set_underrun = 1'b0;
        pix_ok = 1'b0;
        case (st)
            lcd_pkg::SH_IDLE: begin
                next_st = lcd_pkg::SH_LOW;
                next_ph_cnt = lo_len - 8'h01;
                next_have_pix = 1'b0;
            end
            lcd_pkg::SH_LOW: begin
                pix_ok = have_pix;
                if (!have_pix) begin
                    if (sh_left != 6'h00) begin
                        next_panel.pixel_data = 4'(sh_word & ((32'h1 << bpp) - 32'h1));
                        next_sh_word = sh_word >> bpp;
                        next_sh_left = sh_left - 6'h01;
                        next_have_pix = 1'b1;
                        pix_ok = 1'b1;
                    end else if (fifo_out_valid) begin
                        fifo_out_ready = 1'b1;
                        next_panel.pixel_data = 4'(fifo_out_data & ((32'h1 << bpp) - 32'h1));
                        next_sh_word = fifo_out_data >> bpp;
                        next_sh_left = per_word - 6'h01;
                        next_have_pix = 1'b1;
                        pix_ok = 1'b1;
                    end else begin
                        set_underrun = 1'b1;
                    end
                end
                // The load cycle is the first low cycle, so a period stays prescale plus one long.
                if (pix_ok && ph_cnt != 8'h00) begin
                    next_ph_cnt = ph_cnt - 8'h01;
                end else if (pix_ok) begin
                    next_st = lcd_pkg::SH_HIGH;
                    next_ph_cnt = hi_len - 8'h01;
                end
            end
            lcd_pkg::SH_HIGH: begin
                if (ph_cnt != 8'h00) begin
                    next_ph_cnt = ph_cnt - 8'h01;
                end else if (line_end) begin
                    next_pix_cnt = '0;
                    next_st = lcd_pkg::SH_LINE;
                    next_ph_cnt = {2'h0, ctrl.pixel_prescale};
                end else begin
                    next_pix_cnt = pix_cnt + `PIX_CNT_W'(1);
                    next_st = lcd_pkg::SH_LOW;
                    next_ph_cnt = lo_len - 8'h01;
                    next_have_pix = 1'b0;
                end
            end
            default: begin
                if (ph_cnt != 8'h00) begin
                    next_ph_cnt = ph_cnt - 8'h01;
                end else begin
                    if (ac_cnt == ctrl.ac_prescale) begin
                        next_ac_cnt = 5'h00;
                        next_panel.ac_bias = !panel.ac_bias;
                    end else begin
                        next_ac_cnt = ac_cnt + 5'h01;
                    end
                    next_st = lcd_pkg::SH_LOW;
                    next_ph_cnt = (lo_len << 1) - 8'h01;
                    next_have_pix = 1'b0;
                end
            end
        endcase
        if (restart) begin
            next_st = lcd_pkg::SH_IDLE;
            next_pix_cnt = '0;
            next_ac_cnt = 5'h00;
            next_sh_left = 6'h00;
            next_have_pix = 1'b0;
            set_underrun = 1'b0;
            fifo_out_ready = 1'b0;
            next_panel.pixel_data = panel.pixel_data;
        end
        next_panel.pixel_shift_clock = (next_st == lcd_pkg::SH_HIGH);
        next_panel.line_pulse = (next_st == lcd_pkg::SH_LINE);
    end

    // Shifter and panel registers.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= lcd_pkg::SH_IDLE;
            ph_cnt <= 8'h00;
            pix_cnt <= '0;
            ac_cnt <= 5'h00;
            sh_word <= 32'h0000_0000;
            sh_left <= 6'h00;
            have_pix <= 1'b0;
            panel <= '0;
        end else begin
            st <= next_st;
            ph_cnt <= next_ph_cnt;
            pix_cnt <= next_pix_cnt;
            ac_cnt <= next_ac_cnt;
            sh_word <= next_sh_word;
            sh_left <= next_sh_left;
            have_pix <= next_have_pix;
            panel <= next_panel;
        end
    end

    // Length of the current high phase, read only by the checks below.
    logic [`PH_CNT_W-1:0] hi_seen;
    always_ff @(posedge sys_clk) begin
        if (srst || !panel.pixel_shift_clock) begin
            hi_seen <= 8'h00;
        end else begin
            hi_seen <= hi_seen + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    ctrl_read_back_a: assert property (
        (ctrl_wr ##1 (reg_rd && !reg_wr && reg_addr == `REG_CTRL_OFF)) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Control register did not read back the written value.");
    fetch_wrap_a: assert property (
        (mem_valid && mem_ready && fetch_last && !restart) |=> mem_addr == '0)
        else $error("Fetch address did not wrap at the buffer end.");
    fetch_step_a: assert property (
        (mem_valid && mem_ready && !fetch_last && !restart) |=> mem_addr == $past(mem_addr) + `FETCH_ADDR_W'(1))
        else $error("Fetch address did not advance.");
    line_count_a: assert property (
        $rose(panel.line_pulse) |-> $past(pix_cnt, 2) == {ctrl.line_length, 4'hf})
        else $error("Line pulse came after the wrong pixel count.");
    high_phase_a: assert property (
        ($fell(panel.pixel_shift_clock) && !$past(restart)) |-> hi_seen == hi_len)
        else $error("Shift clock high phase has the wrong length.");
    zero_prescale_a: assert property (
        !run |=> ##1 !panel.pixel_shift_clock && !panel.line_pulse)
        else $error("Shift clock ran with a zero prescale.");
    stretch_low_a: assert property (
        (st == lcd_pkg::SH_LINE && next_st == lcd_pkg::SH_LOW) |=> ph_cnt == (lo_len << 1) - 8'h01)
        else $error("Low phase after the line pulse was not doubled.");
    ac_toggle_a: assert property (
        (st == lcd_pkg::SH_LINE && ph_cnt == 8'h00 && !restart && ac_cnt == ctrl.ac_prescale)
        |=> panel.ac_bias != $past(panel.ac_bias))
        else $error("AC bias did not toggle after n+1 line pulses.");
    mono_pixel_a: assert property (
        (!ctrl.gray_output_enable && $changed(panel.pixel_data)) |-> panel.pixel_data[3:1] == 3'h0)
        else $error("Monochrome pixel wider than one bit.");
    gray_depth_a: assert property (
        (ctrl.gray_output_enable && !ctrl.gray_depth_select && $changed(panel.pixel_data))
        |-> panel.pixel_data[3:2] == 2'h0)
        else $error("Two-bit grayscale pixel wider than two bits.");

    line_seen_c: cover property ($rose(panel.line_pulse));
    ac_flip_c: cover property ($changed(panel.ac_bias));
    frame_wrap_c: cover property (mem_valid && mem_ready && fetch_last);
    underrun_c: cover property ($rose(underrun));
endmodule

// >>> verification/lcd_panel_model.sv
// Passive panel model: measures shift clock phases, line pulses, AC bias and pixels.
// Assumes panel pins are registered on sys_clk and sampled on its rising edge.
`timescale 1ns/1ps
module lcd_panel_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Panel pins.
    input wire lcd_pkg::panel_s panel
);
    int rises, lines, toggles, line_pix, pix_run, run, high_len, norm_low, post_low;
    logic after_line, prev_clk, prev_line, prev_ac;
    logic [3:0] cap [0:7];

    // Restarts the rise, line, toggle and per-line pixel counts after a control write.
    task automatic clear_stats();
        rises = 0;
        lines = 0;
        toggles = 0;
        pix_run = 0;
    endtask

    // Counts cycles per phase; the low phase after a line pulse is kept apart.
    always @(posedge sys_clk) begin
        if (srst || panel.line_pulse) begin
            run = 0;
            after_line = panel.line_pulse;
        end else if (panel.pixel_shift_clock !== prev_clk) begin
            if (panel.pixel_shift_clock) begin
                if (after_line) post_low = run;
                else norm_low = run;
                after_line = 0;
                if (rises < 8) cap[rises] = panel.pixel_data;
                rises++;
                pix_run++;
            end else begin
                high_len = run;
            end
            run = 1;
        end else begin
            run++;
        end
        if (panel.line_pulse && !prev_line) begin
            lines++;
            line_pix = pix_run;
            pix_run = 0;
        end
        if (panel.ac_bias !== prev_ac) toggles++;
        prev_clk = panel.pixel_shift_clock;
        prev_line = panel.line_pulse;
        prev_ac = panel.ac_bias;
    end
endmodule

// >>> verification/lcd_timing_control_test.sv
// Testbench for the display timing core: register port, fetch source and panel model.
// Assumes the package and constants header are compiled first; sys_clk is 20 MHz.
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_timing_control_test;
    logic sys_clk, srst, reg_wr, reg_rd, mem_valid, mem_ready;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_data, d, word;
    logic [14:0] mem_addr, max_addr;
    lcd_pkg::panel_s panel;
    int err_total, check_count, taken, t0, k, m, i, n, bpp, mask;

    lcd_timing_control i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_valid(mem_valid), .mem_data(mem_data),
        .mem_ready(mem_ready), .panel(panel));
    lcd_panel_model i_panel (.sys_clk(sys_clk), .srst(srst), .panel(panel));

    // Clock of 50 ns period.
    always #25 sys_clk = ~sys_clk;

    // Counts accepted words and the highest fetch address seen.
    always @(posedge sys_clk) begin
        if (mem_valid && mem_ready) taken++;
        if (mem_addr > max_addr) max_addr = mem_addr;
    end

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ends the run when a bounded wait runs out.
    task automatic expired();
        err_total++;
        $display("ERROR t=%0t wait expired", $time);
        conclude();
    endtask

    // One-cycle write strobe.
    task automatic wr(logic [3:0] a, logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; data are taken in the following cycle only.
    task automatic rd(logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        v = reg_rdata;
    endtask

    // Write strobe followed at once by a read strobe, with no idle cycle between them.
    task automatic wr_rd(logic [3:0] a, logic [31:0] v, output logic [31:0] r);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        r = reg_rdata;
    endtask

    // Control word built from the documented field positions.
    function automatic logic [31:0] ctrl(logic gmd, logic gen, logic [4:0] ac, logic [5:0] pre,
        logic [5:0] ll, logic [12:0] bs);
        return {gmd, gen, ac, pre, ll, bs};
    endfunction

    // Writes the control register, lets the restart settle one edge, then restarts the bench counts.
    task automatic cw(logic [31:0] v);
        wr(`REG_CTRL_OFF, v);
        @(posedge sys_clk);
        i_panel.clear_stats();
        taken = 0;
        max_addr = 0;
    endtask

    // Waits for the next rising line pulse.
    task automatic wait_line();
        for (n = 0; n < 3000 && panel.line_pulse; n++) @(posedge sys_clk);
        for (n = 0; n < 3000 && !panel.line_pulse; n++) @(posedge sys_clk);
        if (n == 3000) expired();
    endtask

    // Main sequence.
    initial begin
        sys_clk = 0;
        srst = 1;
        reg_addr = 0;
        reg_wdata = 0;
        reg_wr = 0;
        reg_rd = 0;
        mem_valid = 0;
        word = 32'h7654_3210;
        mem_data = word;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values, readback and an unmapped offset.
        rd(`REG_CTRL_OFF, d);
        chk(d, `CTRL_RESET);
        rd(`REG_STAT_OFF, d);
        chk(d & 32'h0000_3f06, 32'h0);
        wr(`REG_CTRL_OFF, 32'hffff_ffff);
        wr(4'h8, 32'h0);
        rd(4'h8, d);
        chk(d, 32'h0);
        rd(`REG_CTRL_OFF, d);
        chk(d, 32'hffff_ffff);
        wr_rd(`REG_CTRL_OFF, 32'h5a5a_a5a5, d);
        chk(d, 32'h5a5a_a5a5);
        $display("test registers done");
        // A zero prescale gives no shift clock and no fetch.
        mem_valid <= 1'b1;
        cw(ctrl(0, 0, 5'd13, 6'd0, 6'd1, 13'd1));
        repeat (100) @(posedge sys_clk);
        chk(i_panel.rises, 0);
        chk(mem_addr, 0);
        rd(`REG_STAT_OFF, d);
        chk(d[2], 0);
        $display("test zero prescale done");
        // Shift clock phases, line length, AC bias rate and fetch wrap.
        cw(ctrl(0, 0, 5'd2, 6'd3, 6'd1, 13'd1));
        wait_line();
        @(posedge sys_clk);
        t0 = i_panel.toggles;
        for (k = 1; k <= 6; k++) begin
            wait_line();
            @(posedge sys_clk);
            chk(i_panel.toggles - t0, k / 3);
        end
        chk(i_panel.high_len, 2);
        chk(i_panel.norm_low, 2);
        chk(i_panel.post_low, 4);
        chk(i_panel.line_pix, 32);
        chk(max_addr, 7);
        chk(taken > 8, 1);
        $display("test timing done");
        // Every combination of the two gray bits.
        for (m = 0; m < 4; m++) begin
            cw(ctrl(m[1], m[0], 5'd13, 6'd1, 6'd1, 13'd1));
            bpp = m[0] ? (m[1] ? 4 : 2) : 1;
            mask = (1 << bpp) - 1;
            for (n = 0; n < 500 && i_panel.rises < 8; n++) @(posedge sys_clk);
            if (n == 500) expired();
            for (i = 0; i < 8; i++) chk(i_panel.cap[i] & mask, (word >> (i * bpp)) & mask);
        end
        $display("test pixel modes done");
        // Fill the FIFO until refused, stall the source, drain it to empty.
        cw(ctrl(1, 1, 5'd13, 6'd63, 6'd1, 13'd1));
        for (n = 0; n < 200 && mem_ready; n++) @(posedge sys_clk);
        if (n == 200) expired();
        chk(mem_ready, 0);
        mem_valid <= 1'b0;
        rd(`REG_STAT_OFF, d);
        chk(d[13:8] >= 31, 1);
        wr(`REG_STAT_OFF, 32'h1);
        rd(`REG_STAT_OFF, d);
        chk(d[0], 0);
        for (k = 0; k < 600; k++) begin
            rd(`REG_STAT_OFF, d);
            if (d[13:8] == 0) break;
            repeat (50) @(posedge sys_clk);
        end
        if (k == 600) expired();
        repeat (600) @(posedge sys_clk);
        rd(`REG_STAT_OFF, d);
        chk(d[0], 1);
        wr(`REG_STAT_OFF, 32'h1);
        rd(`REG_STAT_OFF, d);
        chk(d[0], 1);
        mem_valid <= 1'b1;
        repeat (100) @(posedge sys_clk);
        wr(`REG_STAT_OFF, 32'h1);
        rd(`REG_STAT_OFF, d);
        chk(d[0], 0);
        $display("test fifo done");
        conclude();
    end
endmodule
